// ==== dmacr_map.vh ====
// Register map, field positions and reset values of the DMA channel register set.
// Included by the top module and the bench; definitions only.
`ifndef DMACR_MAP_VH
`define DMACR_MAP_VH

// Per-channel window: channel index in paddr[7:5], register in paddr[4:0]
`define DMACR_OFS_CON      5'h00
`define DMACR_OFS_REQ      5'h04
`define DMACR_OFS_BSA      5'h08
`define DMACR_OFS_BSB      5'h0c
`define DMACR_OFS_PAD      5'h10
`define DMACR_OFS_TLY      5'h14
// Shared status registers
`define DMACR_OFS_CS0      12'h100
`define DMACR_OFS_CS1      12'h104

// Writable bits of each register
`define DMACR_CON_MASK     16'hf833
`define DMACR_REQ_MASK     16'h007f
`define DMACR_TLY_MASK     16'h03ff

// Control fields
`define DMACR_CON_ON       15
`define DMACR_CON_BYTE     14
`define DMACR_CON_DIR      13
`define DMACR_CON_HALF     12
`define DMACR_CON_NULL     11
`define DMACR_CON_AM_HI    5
`define DMACR_CON_AM_LO    4
`define DMACR_CON_MD_HI    1
`define DMACR_CON_MD_LO    0
`define DMACR_REQ_FORCE    15

// Addressing scheme codes
`define DMACR_AM_POSTINC   2'h0

// Reset values
`define DMACR_RST_16       16'h0000
`define DMACR_RST_LAST     4'hf

`endif

// ==== dmacr_chan.v ====
// One channel's address pointer, block tally and buffer selection.
// Assumes a one-cycle step pulse from the sequencer per completed transfer.
`timescale 1ns/100ps

module dmacr_chan #(
  parameter TLY_W = 10
) (
  input  wire             ref_clk,
  input  wire             rstn,
  input  wire             on,
  input  wire             byte_mode,
  input  wire             post_inc,
  input  wire             half_irq,
  input  wire [1:0]       mode,
  input  wire [15:0]      base_a,
  input  wire [15:0]      base_b,
  input  wire [TLY_W-1:0] tally,
  input  wire             step,
  output reg  [15:0]      ptr_q,
  output reg              pp_q,
  output wire             irq_hit,
  output wire             stop_hit
);

  reg  [TLY_W-1:0] idx_q;
  wire             last    = (idx_q == tally);
  wire             half_pt = (idx_q == (tally >> 1));
  wire             ping    = mode[1];
  wire [15:0]      incr    = byte_mode ? 16'h0001 : 16'h0002;

  assign irq_hit  = step & (half_irq ? half_pt : last);
  // One-shot ends after one block, or after the second buffer in ping-pong
  assign stop_hit = step & last & mode[0] & (~ping | pp_q);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= {TLY_W{1'b0}};
      ptr_q <= 16'h0000;
      pp_q  <= 1'b0;
    end else if (!on) begin
      // Idle channel tracks buffer A so enabling starts at its base
      idx_q <= {TLY_W{1'b0}};
      ptr_q <= base_a;
      pp_q  <= 1'b0;
    end else if (step) begin
      if (last) begin
        idx_q <= {TLY_W{1'b0}};
        if (ping) begin
          pp_q  <= ~pp_q;
          ptr_q <= pp_q ? base_a : base_b;
        end else begin
          ptr_q <= base_a;
        end
      end else begin
        idx_q <= idx_q + {{(TLY_W-1){1'b0}}, 1'b1};
        if (post_inc) begin
          ptr_q <= ptr_q + incr;
        end
      end
    end
  end

endmodule // dmacr_chan

// ==== dmacr_top.v ====
// Eight-channel DMA configuration registers, request selection and sequencer.
// Assumes APB from software, request pulses and xfer_done from logic on ref_clk.
`timescale 1ns/100ps
`include "dmacr_map.vh"

// What this block does
// - Eight channels, each with control, select, two bases, peripheral address, tally.
// - Shared collision flags register and last-serviced channel plus ping-pong status register.
// - Buffer base reads return the live RAM pointer; writes set the stored base.
// - Per-channel interrupt pulses go out; flag, enable and priority live elsewhere.
// - Control bit 15 enables the channel.
// - Control bit 14 picks byte transfers, else words.
// - Control bit 13 set moves RAM to peripheral, clear peripheral to RAM.
// - Control bit 12 raises the block interrupt at half block, else at end.
// - Control bit 11 adds a null peripheral write; only with direction clear.
// - Bits 5-4: post-increment, no increment, peripheral indirect; 11 acts indirect.
// - Bits 1-0: continuous, one-shot, ping-pong continuous, ping-pong one-shot.
// - Unimplemented bits ignore writes and read zero.
// - Select bit 15 forces one transfer; else the selected request starts transfers.
// - Writing zero leaves the force bit; hardware clears it after the transfer.
// - Bits 6-0 pick one of 128 peripheral request lines.
// - Primary base holds the first RAM buffer start.
// - Secondary base holds the alternate RAM buffer start for ping-pong.
// - Peripheral address register holds the peripheral register address.
// - A block is the programmed tally plus one transfers.
// - Ping-pong swaps buffer bases after each completed block.
// - Simultaneous requests are granted by fixed channel priority.
module dmacr_top #(
  parameter NCH   = 8,
  parameter NREQ  = 128,
  parameter TLY_W = 10
) (
  input  wire          ref_clk,
  input  wire          rstn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire [127:0]  periph_req,
  input  wire          xfer_done,
  input  wire [7:0]    ram_clash,
  input  wire [7:0]    periph_clash,
  output reg           xfer_valid,
  output reg  [2:0]    xfer_chan,
  output reg  [15:0]   xfer_ram_addr,
  output reg  [15:0]   xfer_periph_addr,
  output reg           xfer_byte,
  output reg           xfer_to_periph,
  output reg           xfer_null_write,
  output reg           xfer_periph_indirect,
  output reg  [7:0]    chan_irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // -------------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------------
  // Lowest channel number wins
  function [2:0] first_one;
    input [7:0] v;
    integer k;
    begin
      first_one = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_one = k[2:0];
        end
      end
    end
  endfunction

  function [7:0] one_hot;
    input [2:0] n;
    begin
      one_hot = 8'h01 << n;
    end
  endfunction

  // -------------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------------
  reg  [15:0]      con_q   [0:NCH-1];
  reg  [6:0]       sel_q   [0:NCH-1];
  reg  [15:0]      bsa_q   [0:NCH-1];
  reg  [15:0]      bsb_q   [0:NCH-1];
  reg  [15:0]      pad_q   [0:NCH-1];
  reg  [TLY_W-1:0] tly_q   [0:NCH-1];
  reg  [7:0]       force_q;
  reg  [7:0]       pend_q;
  reg  [7:0]       ramcol_q;
  reg  [7:0]       percol_q;
  reg  [3:0]       last_q;
  reg              state_q;
  reg              forced_q;

  wire [127:0]     ptr_flat;
  wire [7:0]       pp_w;
  wire [7:0]       irq_w;
  wire [7:0]       stop_w;
  wire [7:0]       on_w;
  wire [7:0]       step_w;
  wire [7:0]       req_hit;

  // -------------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------------
  wire        in_chan  = (paddr[11:8] == 4'h0);
  wire [2:0]  dec_ch   = paddr[7:5];
  wire [4:0]  dec_reg  = paddr[4:0];
  wire        hit_cs0  = (paddr == `DMACR_OFS_CS0);
  wire        hit_cs1  = (paddr == `DMACR_OFS_CS1);
  wire        hit_con  = in_chan & (dec_reg == `DMACR_OFS_CON);
  wire        hit_req  = in_chan & (dec_reg == `DMACR_OFS_REQ);
  wire        hit_bsa  = in_chan & (dec_reg == `DMACR_OFS_BSA);
  wire        hit_bsb  = in_chan & (dec_reg == `DMACR_OFS_BSB);
  wire        hit_pad  = in_chan & (dec_reg == `DMACR_OFS_PAD);
  wire        hit_tly  = in_chan & (dec_reg == `DMACR_OFS_TLY);
  wire        hit_any  = hit_con | hit_req | hit_bsa | hit_bsb | hit_pad | hit_tly
                         | hit_cs0 | hit_cs1;
  // Write lands only at the access edge that sees pready
  wire        wr_en    = psel & penable & pready & pwrite & hit_any;
  wire [15:0] wd       = pwdata[15:0];
  wire [7:0]  wr_ch    = one_hot(dec_ch);

  reg  [15:0] rd_d;

  always @* begin
    rd_d = 16'h0000;
    if (hit_con) begin
      rd_d = con_q[dec_ch] & `DMACR_CON_MASK;
    end else if (hit_req) begin
      rd_d = {force_q[dec_ch], 8'h00, sel_q[dec_ch]};
    end else if (hit_bsa | hit_bsb) begin
      rd_d = ptr_flat[16*dec_ch +: 16];
    end else if (hit_pad) begin
      rd_d = pad_q[dec_ch];
    end else if (hit_tly) begin
      rd_d = {{(16-TLY_W){1'b0}}, tly_q[dec_ch]};
    end else if (hit_cs0) begin
      rd_d = {percol_q, ramcol_q};
    end else if (hit_cs1) begin
      rd_d = {4'h0, last_q, pp_w};
    end
  end

  // One setup cycle, answer in the first access cycle
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata  <= {16'h0000, rd_d};
      pready  <= 1'b1;
      pslverr <= ~hit_any;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Channel configuration registers
  // -------------------------------------------------------------------------
  integer c;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (c = 0; c < NCH; c = c + 1) begin
        con_q[c] <= `DMACR_RST_16;
        sel_q[c] <= 7'h00;
        bsa_q[c] <= `DMACR_RST_16;
        bsb_q[c] <= `DMACR_RST_16;
        pad_q[c] <= `DMACR_RST_16;
        tly_q[c] <= {TLY_W{1'b0}};
      end
    end else begin
      for (c = 0; c < NCH; c = c + 1) begin
        // Software write wins over the one-shot self-disable
        if (wr_en & hit_con & wr_ch[c]) begin
          con_q[c] <= wd & `DMACR_CON_MASK;
        end else if (stop_w[c]) begin
          con_q[c][`DMACR_CON_ON] <= 1'b0;
        end
        if (wr_en & hit_req & wr_ch[c]) begin
          sel_q[c] <= wd[6:0];
        end
        if (wr_en & hit_bsa & wr_ch[c]) begin
          bsa_q[c] <= wd;
        end
        if (wr_en & hit_bsb & wr_ch[c]) begin
          bsb_q[c] <= wd;
        end
        if (wr_en & hit_pad & wr_ch[c]) begin
          pad_q[c] <= wd;
        end
        if (wr_en & hit_tly & wr_ch[c]) begin
          tly_q[c] <= wd[TLY_W-1:0];
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Requests, force bits and collision flags
  // -------------------------------------------------------------------------
  wire [7:0] force_set = (wr_en & hit_req & wd[`DMACR_REQ_FORCE]) ? wr_ch : 8'h00;
  wire [7:0] done_oh   = (state_q == ST_BUSY && xfer_done) ? one_hot(xfer_chan) : 8'h00;
  wire [7:0] force_clr = forced_q ? done_oh : 8'h00;
  wire       grant     = (state_q == ST_IDLE) && (|(pend_q & on_w));
  wire [2:0] gnt_ch    = first_one(pend_q & on_w);
  wire [7:0] gnt_oh    = grant ? one_hot(gnt_ch) : 8'h00;
  wire [7:0] cs0_clr_p = (wr_en & hit_cs0) ? ~wd[15:8] : 8'h00;
  wire [7:0] cs0_clr_r = (wr_en & hit_cs0) ? ~wd[7:0] : 8'h00;

  assign step_w = done_oh;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      assign on_w[g]    = con_q[g][`DMACR_CON_ON];
      // Forced channels ignore their request line
      assign req_hit[g] = periph_req[sel_q[g]] & ~force_q[g];

      dmacr_chan #(
        .TLY_W     (TLY_W)
      ) u_chan (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .on        (on_w[g]),
        .byte_mode (con_q[g][`DMACR_CON_BYTE]),
        .post_inc  (con_q[g][`DMACR_CON_AM_HI:`DMACR_CON_AM_LO] == `DMACR_AM_POSTINC),
        .half_irq  (con_q[g][`DMACR_CON_HALF]),
        .mode      (con_q[g][`DMACR_CON_MD_HI:`DMACR_CON_MD_LO]),
        .base_a    (bsa_q[g]),
        .base_b    (bsb_q[g]),
        .tally     (tly_q[g]),
        .step      (step_w[g]),
        .ptr_q     (ptr_flat[16*g +: 16]),
        .pp_q      (pp_w[g]),
        .irq_hit   (irq_w[g]),
        .stop_hit  (stop_w[g])
      );
    end
  endgenerate

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      force_q  <= 8'h00;
      pend_q   <= 8'h00;
      ramcol_q <= 8'h00;
      percol_q <= 8'h00;
      chan_irq <= 8'h00;
    end else begin
      // Zero writes never clear force; a new set beats completion
      force_q  <= (force_q & ~force_clr) | (force_set & on_w);
      // A disabled channel drops whatever it had pending
      pend_q   <= ((pend_q & ~gnt_oh) | ((req_hit | force_set) & on_w)) & on_w;
      ramcol_q <= (ramcol_q & ~cs0_clr_r) | ram_clash;
      percol_q <= (percol_q & ~cs0_clr_p) | periph_clash;
      chan_irq <= irq_w;
    end
  end

  // -------------------------------------------------------------------------
  // Transfer sequencer
  // -------------------------------------------------------------------------
  wire [15:0] g_con = con_q[gnt_ch];
  wire        g_dir = g_con[`DMACR_CON_DIR];

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q              <= ST_IDLE;
      forced_q             <= 1'b0;
      last_q               <= `DMACR_RST_LAST;
      xfer_valid           <= 1'b0;
      xfer_chan            <= 3'h0;
      xfer_ram_addr        <= 16'h0000;
      xfer_periph_addr     <= 16'h0000;
      xfer_byte            <= 1'b0;
      xfer_to_periph       <= 1'b0;
      xfer_null_write      <= 1'b0;
      xfer_periph_indirect <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (grant) begin
            state_q              <= ST_BUSY;
            forced_q             <= force_q[gnt_ch];
            xfer_valid           <= 1'b1;
            xfer_chan            <= gnt_ch;
            xfer_ram_addr        <= ptr_flat[16*gnt_ch +: 16];
            xfer_periph_addr     <= pad_q[gnt_ch];
            xfer_byte            <= g_con[`DMACR_CON_BYTE];
            xfer_to_periph       <= g_dir;
            xfer_null_write      <= g_con[`DMACR_CON_NULL] & ~g_dir;
            xfer_periph_indirect <= g_con[`DMACR_CON_AM_HI];
          end
        end
        ST_BUSY: begin
          if (xfer_done) begin
            state_q    <= ST_IDLE;
            xfer_valid <= 1'b0;
            last_q     <= {1'b0, xfer_chan};
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          xfer_valid <= 1'b0;
        end
      endcase
    end
  end

endmodule // dmacr_top

// ==== dmacr_sva.sv ====
// Checker for dmacr_top: APB answer timing and transfer output behaviour.
// Assumes binding to dmacr_top; sees only its ports.
`timescale 1ns/100ps

module dmacr_sva (
  input wire        ref_clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        xfer_done,
  input wire        xfer_valid,
  input wire [2:0]  xfer_chan,
  input wire [15:0] xfer_ram_addr,
  input wire [15:0] xfer_periph_addr,
  input wire        xfer_byte,
  input wire        xfer_to_periph,
  input wire [7:0]  chan_irq
);
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  error_read_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  upper_half_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  fields_hold_a: assert property (xfer_valid && !xfer_done |=> xfer_valid &&
    $stable(xfer_chan) && $stable(xfer_ram_addr) && $stable(xfer_periph_addr) &&
    $stable(xfer_byte) && $stable(xfer_to_periph))
    else $error("transfer fields moved");
  valid_drop_a: assert property (xfer_valid && xfer_done |=> !xfer_valid)
    else $error("valid held past done");
  irq_single_a: assert property (chan_irq != 8'h0 |-> $onehot(chan_irq) ##1 chan_irq == 8'h0)
    else $error("interrupt not a single pulse");
  irq_cause_a: assert property (chan_irq != 8'h0 |-> $past(xfer_valid) &&
    $past(xfer_done) && chan_irq == (8'h01 << $past(xfer_chan)))
    else $error("interrupt without completed transfer");
endmodule // dmacr_sva

bind dmacr_top dmacr_sva dmacr_sva_inst (.ref_clk, .rstn, .psel, .penable, .prdata, .pready,
  .pslverr, .xfer_done, .xfer_valid, .xfer_chan, .xfer_ram_addr, .xfer_periph_addr,
  .xfer_byte, .xfer_to_periph, .chan_irq);

// ==== dmacr_periph_model.sv ====
// Peripheral side: request pulses on command, transfer completion after a latency.
// Assumes the bench sets req_go, req_line and lat on ref_clk.
`timescale 1ns/100ps

module dmacr_periph_model (
  input  wire         ref_clk,
  input  wire         rstn,
  input  wire         req_go,
  input  wire [6:0]   req_line,
  input  wire [3:0]   lat,
  input  wire         xfer_valid,
  output reg  [127:0] periph_req,
  output reg          xfer_done
);
  reg [3:0] wait_q;

  // Latency varies so that slow peripherals hold the transfer open
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      periph_req <= 128'h0;
      xfer_done <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      periph_req <= req_go ? (128'h1 << req_line) : 128'h0;
      wait_q <= (!xfer_valid || xfer_done) ? 4'h0 : wait_q + 4'h1;
      xfer_done <= xfer_valid && !xfer_done && (wait_q >= lat);
    end
  end
endmodule // dmacr_periph_model

// ==== tb_dma_channel_config_regs.sv ====
// Self-checking bench for dmacr_top: APB register access and channel transfers.
// Assumes dmacr_map.vh on the include path and the peripheral model beside it.
`timescale 1ns/100ps
`include "dmacr_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module tb_dma_channel_config_regs;
  typedef struct packed {
    logic [2:0]  chan;
    logic [15:0] ram;
    logic [15:0] pad;
    logic [3:0]  flags;
  } dmacr_xfer_t;
  logic         ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic         pready, pslverr, xfer_done, xfer_valid, xfer_byte, xfer_to_periph, er;
  logic         xfer_null_write, xfer_periph_indirect, req_go = 1'b0, sz, dir, half, nul;
  logic [1:0]   am, md;
  logic [2:0]   xfer_chan;
  logic [3:0]   lat = 4'h0;
  logic [6:0]   req_line = 7'h0, sel;
  logic [7:0]   chan_irq, ram_clash = 8'h0, periph_clash = 8'h0;
  logic [11:0]  paddr = 12'h0;
  logic [15:0]  xfer_ram_addr, xfer_periph_addr, con, ba, bb, pad, bufa;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic [127:0] periph_req;
  int           err_total = 0, comparisons = 0, cycles = 0, irq_n[8], ch, nt, n0, thr, st;
  dmacr_xfer_t  seen[$];
  dmacr_xfer_t  x;

  dmacr_top dmacr_top_inst (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periph_req, .xfer_done, .ram_clash, .periph_clash,
    .xfer_valid, .xfer_chan, .xfer_ram_addr, .xfer_periph_addr, .xfer_byte,
    .xfer_to_periph, .xfer_null_write, .xfer_periph_indirect, .chan_irq);
  dmacr_periph_model dmacr_periph_model_inst (.ref_clk, .rstn, .req_go, .req_line, .lat,
    .xfer_valid, .periph_req, .xfer_done);

  always #4 ref_clk = ~ref_clk;

  // ----------
  // Monitor and timeout
  // ----------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
    if (xfer_valid === 1'b1 && xfer_done === 1'b1)
      seen.push_back({xfer_chan, xfer_ram_addr, xfer_periph_addr, xfer_byte,
                      xfer_to_periph, xfer_null_write, xfer_periph_indirect});
    for (int i = 0; i < 8; i++)
      irq_n[i] += chan_irq[i];
  end

  task automatic conclude;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      err_total++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0, rd, er);
    `CHK(rd, exp)
  endtask

  task automatic pulse(input logic [6:0] l);
    @(posedge ref_clk);
    req_go <= 1'b1;
    req_line <= l;
    @(posedge ref_clk);
    req_go <= 1'b0;
  endtask

  task automatic wait_seen(input int n);
    int k;
    k = 0;
    while (seen.size() < n && k < 300) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (2) @(posedge ref_clk);
    `CHK(seen.size(), n)
  endtask

  function automatic logic [11:0] ra(input int c, input logic [4:0] o);
    return 12'(c * 32) + {7'h0, o};
  endfunction

  initial begin
    void'($urandom(3248));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int c = 0; c < 48; c++)
      rdc(ra(c / 6, 5'((c % 6) * 4)), 32'h0);
    rdc(`DMACR_OFS_CS1, 32'h0f00);
    apb(1'b0, 12'h108, 16'h0, rd, er);
    `CHK({er, rd}, 33'h100000000)
    for (int c = 0; c < 8; c++) begin
      con = 16'($urandom) & 16'h7fff;
      ba = 16'($urandom);
      wr(ra(c, `DMACR_OFS_CON), con);
      wr(ra(c, `DMACR_OFS_REQ), con);
      wr(ra(c, `DMACR_OFS_BSA), ba);
      wr(ra(c, `DMACR_OFS_BSB), ~ba);
      wr(ra(c, `DMACR_OFS_PAD), ~con);
      wr(ra(c, `DMACR_OFS_TLY), con);
      rdc(ra(c, `DMACR_OFS_CON), {16'h0, con & 16'hf833});
      rdc(ra(c, `DMACR_OFS_REQ), {16'h0, con & 16'h007f});
      rdc(ra(c, `DMACR_OFS_BSB), {16'h0, ba});
      rdc(ra(c, `DMACR_OFS_PAD), {16'h0, ~con});
      rdc(ra(c, `DMACR_OFS_TLY), {16'h0, con & 16'h03ff});
    end
    for (int m = 0; m < 4; m++) begin
      ch = 2 * m + 1;
      {sz, dir, half, nul} = 4'($urandom);
      nul = nul & ~dir;
      am = 2'(3 - m);
      md = 2'(m);
      sel = 7'($urandom);
      nt = 1 + $urandom % 4;
      ba = {15'($urandom), 1'b0};
      bb = {15'($urandom), 1'b0};
      pad = 16'($urandom);
      con = {1'b1, sz, dir, half, nul, 5'h0, am, 2'h0, md};
      wr(ra(ch, `DMACR_OFS_BSA), ba);
      wr(ra(ch, `DMACR_OFS_BSB), bb);
      wr(ra(ch, `DMACR_OFS_PAD), pad);
      wr(ra(ch, `DMACR_OFS_TLY), 16'(nt));
      wr(ra(ch, `DMACR_OFS_REQ), {9'h0, sel});
      wr(ra(ch, `DMACR_OFS_CON), con);
      st = am[0] ? 0 : (sz ? 1 : 2);
      thr = half ? nt / 2 + 1 : nt + 1;
      n0 = seen.size();
      for (int b = 0; b < (md == 2'h1 ? 1 : 2); b++) begin
        bufa = (md[1] && b == 1) ? bb : ba;
        for (int j = 0; j <= nt; j++) begin
          lat <= 4'($urandom % 4);
          pulse(sel);
          wait_seen(n0 + 1);
          x = seen[n0];
          n0++;
          `CHK({x.chan, x.flags}, {3'(ch), sz, dir, nul, am[1]})
          if (!am[1])
            `CHK({x.ram, x.pad}, {bufa + 16'(j * st), pad})
          `CHK(irq_n[ch], b + int'(j + 1 >= thr))
          if (b == 0 && j == 0 && !am[1])
            rdc(ra(ch, `DMACR_OFS_BSA), {16'h0, ba + 16'(st)});
        end
        rdc(`DMACR_OFS_CS1, {20'h0, 4'(ch), 8'(int'(md[1] && b == 0) << ch)});
      end
      rdc(ra(ch, `DMACR_OFS_CON), {16'h0, con & (md[0] ? 16'h7fff : 16'hffff)});
      wr(ra(ch, `DMACR_OFS_CON), 16'h0);
    end
    wr(ra(6, `DMACR_OFS_CON), 16'h8000);
    lat <= 4'hc;
    n0 = seen.size();
    wr(ra(6, `DMACR_OFS_REQ), 16'h8005);
    wr(ra(6, `DMACR_OFS_REQ), 16'h0005);
    rdc(ra(6, `DMACR_OFS_REQ), 32'h8005);
    wait_seen(n0 + 1);
    rdc(ra(6, `DMACR_OFS_REQ), 32'h0005);
    lat <= 4'h0;
    wr(ra(6, `DMACR_OFS_CON), 16'h0);
    for (int c = 2; c < 8; c++)
      wr(ra(c, `DMACR_OFS_REQ), 16'h0009);
    wr(ra(7, `DMACR_OFS_CON), 16'h8000);
    wr(ra(2, `DMACR_OFS_CON), 16'h8000);
    n0 = seen.size();
    pulse(7'h09);
    wait_seen(n0 + 2);
    `CHK({seen[n0].chan, seen[n0 + 1].chan}, {3'h2, 3'h7})
    ram_clash <= 8'h08;
    periph_clash <= 8'h40;
    @(posedge ref_clk);
    ram_clash <= 8'h00;
    periph_clash <= 8'h00;
    rdc(`DMACR_OFS_CS0, 32'h4008);
    wr(`DMACR_OFS_CS0, 16'hfff7);
    rdc(`DMACR_OFS_CS0, 32'h4000);
    conclude();
  end
endmodule // tb_dma_channel_config_regs
